// ### src/asc_pkg.sv
// Constants and types shared by the serial core modules.
// Assumes one 8-bit register port and one core clock.
package asc_pkg;
   // Register addresses
   localparam logic [15:0] MODE_ADDR  = 16'hFF50;
   localparam logic [15:0] TXBUF_ADDR = 16'hFF51;
   localparam logic [15:0] RXBUF_ADDR = 16'hFF52;
   localparam logic [15:0] ERRST_ADDR = 16'hFF53;
   localparam logic [15:0] TXST_ADDR  = 16'hFF55;
   // Values after reset
   localparam logic [7:0]  MODE_RST   = 8'h01;
   localparam logic [7:0]  ERRST_RST  = 8'h00;
   localparam logic [7:0]  BUF_RST    = 8'hFF;
   // Mode register fields
   localparam int          MODE_POWER = 7;
   localparam int          MODE_TXEN  = 6;
   localparam int          MODE_RXEN  = 5;
   localparam int          MODE_PAR_HI = 4;
   localparam int          MODE_PAR_LO = 3;
   localparam int          MODE_LEN   = 2;
   localparam int          MODE_STOP  = 1;
   localparam int          MODE_ROUTE = 0;
   // Error status and transmit status fields
   localparam int          ERR_PAR    = 2;
   localparam int          ERR_FRM    = 1;
   localparam int          ERR_OVR    = 0;
   localparam int          TXST_FULL  = 1;
   localparam int          TXST_BUSY  = 0;
   // Cycle counts: base clocks per bit, core clocks per base clock
   localparam int          BIT_TICKS_DEF = 510;
   localparam int          BASE_DIV_DEF  = 1;

   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_ZERO = 2'h1,
      PAR_ODD  = 2'h2,
      PAR_EVEN = 2'h3
   } asc_par_t;

   typedef enum logic [2:0] {
      FR_IDLE  = 3'h0,
      FR_START = 3'h1,
      FR_DATA  = 3'h3,
      FR_PAR   = 3'h2,
      FR_STOP  = 3'h6,
      FR_STOP2 = 3'h7
   } asc_frame_t;
endpackage

// ### src/asc_tx_if.sv
// Signals between the core and its transmitter.
// Assumes both ends run on the core clock.
interface asc_tx_if;
   logic                tick;
   logic                en;
   asc_pkg::asc_par_t   par;
   logic                len8;
   logic                stop2;
   logic                msb;
   logic [7:0]          data;
   logic                full;
   logic                take;
   logic                done;
   logic                busy;
   logic                pin;

   modport core (output tick, en, par, len8, stop2, msb, data, full,
                 input  take, done, busy, pin);
   modport tx   (input  tick, en, par, len8, stop2, msb, data, full,
                 output take, done, busy, pin);
endinterface

// ### src/asc_front.sv
// Serial input synchroniser and base clock strobe.
// Assumes the input pin is asynchronous to clk.
module asc_front #(
   parameter int BASE_DIV = asc_pkg::BASE_DIV_DEF
) (
   // Clock and resets
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic unit_off,
   // Pin and outputs
   input  wire logic serial_in_pin,
   output logic      rx_level,
   output logic      tick
);
   localparam int DW = $clog2(BASE_DIV + 1);
   logic [2:0]    sy_q;
   logic [DW-1:0] div_q;

   always_ff @(posedge clk or posedge unit_off) begin
      // R11 input held high
      if (unit_off) begin
         sy_q     <= 3'h7;
         rx_level <= 1'b1;
         div_q    <= '0;
         tick     <= 1'b0;
      end else if (sys_rst) begin
         sy_q     <= 3'h7;
         rx_level <= 1'b1;
         div_q    <= '0;
         tick     <= 1'b0;
      end else if (ce) begin
         sy_q <= {sy_q[1:0], serial_in_pin};
         // Level counts only once stages two and three agree
         if (sy_q[2] == sy_q[1]) begin
            rx_level <= sy_q[2];
         end
         // R8 strobe stays low while off
         if (div_q == DW'(BASE_DIV - 1)) begin
            div_q <= '0;
            tick  <= 1'b1;
         end else begin
            div_q <= div_q + 1'b1;
            tick  <= 1'b0;
         end
      end
   end
endmodule

// ### src/asc_tx.sv
// Transmit shifter and frame sequencer.
// Assumes tick is a one-cycle strobe at each base clock falling edge.
module asc_tx #(
   parameter int BIT_TICKS = asc_pkg::BIT_TICKS_DEF
) (
   // Clock and resets
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic unit_off,
   // Core side
   asc_tx_if.tx      tif
);
   localparam int CW = $clog2(BIT_TICKS);
   asc_pkg::asc_frame_t st_q;
   logic [CW-1:0]       cnt_q;
   logic [7:0]          sh_q;
   logic [7:0]          sh_nx;
   logic [2:0]          nb_q;
   logic                pb_q;
   logic                pb_d;
   logic                bit_end;
   logic                cur;
   logic                fin;
   logic                start_now;
   logic                px;
   logic [7:0]          mask;

   assign bit_end = tif.tick && (cnt_q == CW'(BIT_TICKS - 1));
   assign cur     = tif.msb ? sh_q[7] : sh_q[0];
   assign sh_nx   = tif.msb ? {sh_q[6:0], 1'b1} : {1'b1, sh_q[7:1]};
   assign mask    = tif.len8 ? 8'hFF : (tif.msb ? 8'hFE : 8'h7F);
   assign px      = ^(tif.data & mask);
   // R12 parity bit choice
   assign pb_d    = (tif.par == asc_pkg::PAR_ODD)  ? ~px :
                    (tif.par == asc_pkg::PAR_EVEN) ? px : 1'b0;
   assign fin     = bit_end && ((st_q == asc_pkg::FR_STOP2) ||
                    (st_q == asc_pkg::FR_STOP && !tif.stop2));
   // R6 reload at frame end when buffer holds data
   assign start_now = tif.full && tif.tick &&
                      ((st_q == asc_pkg::FR_IDLE) || fin);
   assign tif.busy = (st_q != asc_pkg::FR_IDLE);

   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         st_q     <= asc_pkg::FR_IDLE;
         cnt_q    <= '0;
         sh_q     <= asc_pkg::BUF_RST;
         nb_q     <= 3'h0;
         pb_q     <= 1'b0;
         tif.pin  <= 1'b1;
         tif.take <= 1'b0;
         tif.done <= 1'b0;
      end else if (sys_rst || (ce && !tif.en)) begin
         // R10 synchronous transmit reset
         st_q     <= asc_pkg::FR_IDLE;
         cnt_q    <= '0;
         sh_q     <= asc_pkg::BUF_RST;
         nb_q     <= 3'h0;
         pb_q     <= 1'b0;
         tif.pin  <= 1'b1;
         tif.take <= 1'b0;
         tif.done <= 1'b0;
      end else if (ce) begin
         tif.take <= 1'b0;
         tif.done <= 1'b0;
         if (tif.tick && st_q != asc_pkg::FR_IDLE) begin
            cnt_q <= bit_end ? '0 : cnt_q + 1'b1;
         end
         // R7 shift on base clock strobe
         unique case (st_q)
            asc_pkg::FR_IDLE: begin
            end
            asc_pkg::FR_START: if (bit_end) begin
               tif.pin <= cur;
               sh_q    <= sh_nx;
               nb_q    <= 3'h0;
               st_q    <= asc_pkg::FR_DATA;
            end
            // R14 seven or eight data bits
            asc_pkg::FR_DATA: if (bit_end) begin
               if (nb_q == (tif.len8 ? 3'h7 : 3'h6)) begin
                  if (tif.par != asc_pkg::PAR_NONE) begin
                     tif.pin <= pb_q;
                     st_q    <= asc_pkg::FR_PAR;
                  end else begin
                     tif.pin <= 1'b1;
                     st_q    <= asc_pkg::FR_STOP;
                  end
               end else begin
                  tif.pin <= cur;
                  sh_q    <= sh_nx;
                  nb_q    <= nb_q + 3'h1;
               end
            end
            asc_pkg::FR_PAR: if (bit_end) begin
               tif.pin <= 1'b1;
               st_q    <= asc_pkg::FR_STOP;
            end
            // R15 second stop bit when selected
            asc_pkg::FR_STOP: if (bit_end) begin
               if (tif.stop2) begin
                  st_q <= asc_pkg::FR_STOP2;
               end else begin
                  tif.done <= 1'b1;
                  st_q     <= asc_pkg::FR_IDLE;
               end
            end
            asc_pkg::FR_STOP2: if (bit_end) begin
               tif.done <= 1'b1;
               st_q     <= asc_pkg::FR_IDLE;
            end
            default: st_q <= asc_pkg::FR_IDLE;
         endcase
         // R5 buffered character starts a frame
         if (start_now) begin
            sh_q     <= tif.data;
            pb_q     <= pb_d;
            tif.take <= 1'b1;
            tif.pin  <= 1'b0;
            cnt_q    <= '0;
            st_q     <= asc_pkg::FR_START;
         end
      end
   end
endmodule

// ### src/asc_core.sv
// Asynchronous serial core: register port, receiver, transmit buffer.
// Assumes a byte-wide register port on clk and an asynchronous rx pin.
//
// Overview of operation
// R1: Seven-bit LSB-first character fills bits 0-6; bit 7 reads zero.
// R2: Seven-bit MSB-first character fills bits 1-7; bit 0 reads zero.
// R3: On overrun the new character is dropped; buffer keeps old value.
// R4: Receive buffer is read-only, resets to FF, loads per character.
// R5: Writing the transmit buffer starts a frame; buffer resets to FF.
// R6: Shifter loads right after first write, or at previous frame end.
// R7: Shifter loads and shifts on the base clock strobe.
// R8: Power bit low stops base clock and asynchronously resets the unit; the interrupt outputs clear only at the next clk edge.
// R9: Mode register layout as listed; resets to 01.
// R10: Clearing an enable synchronously resets that direction.
// R11: Powered off, output pin idles high and input reads high.
// R12: Parity codes: none, zero, odd, even.
// R13: Zero parity is never checked and never flags an error.
// R14: Length bit picks seven or eight data bits both ways.
// R15: Stop bit count affects transmit only; receiver uses one.
// R16: Routing bit picks error or completion interrupt on errors.
// R17: Software waits two base clocks before re-enabling.
// R18: Software writes transmit buffer only when not full.
// R19: Software powers up before enabling, disables before power off.
// R20: Enabling reception on a low line starts a reception.
// R21: Software changes format only with directions disabled.
// R22: Error status is read-only, cleared by read, reset or disable.
// R23: Parity and framing errors flagged at character end.
// R24: Overrun flagged when previous character is still unread.
// R25: Only the first stop bit decides framing error.
// R26: Error flags update with buffer load and interrupt pulse.
module asc_core #(
   parameter int BIT_TICKS = asc_pkg::BIT_TICKS_DEF,
   parameter int BASE_DIV  = asc_pkg::BASE_DIV_DEF
) (
   // Clock, reset, clock enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   // Register port
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   output logic      [7:0]  bus_rdata,
   // Bit order, set by logic on this clock
   input  wire logic        msb_first,
   // Serial pins
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   // Interrupt pulses
   output logic             transmit_done_irq,
   output logic             receive_done_irq,
   output logic             receive_error_irq
);
   localparam int CW   = $clog2(BIT_TICKS);
   localparam int HALF = BIT_TICKS / 2;

   logic [7:0]          mode_q;
   logic [7:0]          txb_q;
   logic [7:0]          rxb_q;
   logic [2:0]          err_q;
   logic [2:0]          err_new;
   logic                full_q;
   logic                unread_q;
   asc_pkg::asc_frame_t rst_q;
   logic [CW-1:0]       rcnt_q;
   logic [7:0]          rsh_q;
   logic [2:0]          rn_q;
   logic                rpar_q;
   logic                power;
   logic                unit_off;
   logic                tx_en;
   logic                rx_en;
   logic                len8;
   logic                route;
   asc_pkg::asc_par_t   par;
   logic                tick;
   logic                rx_level;
   logic                r_end;
   logic                rx_fin;
   logic                rx_load;
   logic [7:0]          rx_res;
   logic                rx_x;
   logic                pe_now;
   logic                wr_mode;
   logic                wr_tx;
   logic                rd_rx;
   logic                rd_err;

   if (BIT_TICKS < 4 || BIT_TICKS > 65536) begin : g_chk_bit
      $error("BIT_TICKS out of range");
   end
   if (BASE_DIV < 1) begin : g_chk_div
      $error("BASE_DIV must be at least one");
   end

   // R9 mode register fields
   assign power    = mode_q[asc_pkg::MODE_POWER];
   assign unit_off = ~power;
   assign tx_en    = power & mode_q[asc_pkg::MODE_TXEN];
   assign rx_en    = power & mode_q[asc_pkg::MODE_RXEN];
   assign par      = asc_pkg::asc_par_t'(
                     mode_q[asc_pkg::MODE_PAR_HI:asc_pkg::MODE_PAR_LO]);
   assign len8     = mode_q[asc_pkg::MODE_LEN];
   assign route    = mode_q[asc_pkg::MODE_ROUTE];

   assign wr_mode = bus_wr && (bus_addr == asc_pkg::MODE_ADDR);
   assign wr_tx   = bus_wr && (bus_addr == asc_pkg::TXBUF_ADDR);
   assign rd_rx   = ce && bus_rd && (bus_addr == asc_pkg::RXBUF_ADDR);
   assign rd_err  = ce && bus_rd && (bus_addr == asc_pkg::ERRST_ADDR);

   asc_front #(
      .BASE_DIV (BASE_DIV)
   ) u_front (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .ce            (ce),
      .unit_off      (unit_off),
      .serial_in_pin (serial_in_pin),
      .rx_level      (rx_level),
      .tick          (tick)
   );

   asc_tx_if tif ();
   assign tif.tick  = tick;
   assign tif.en    = tx_en;
   assign tif.par   = par;
   assign tif.len8  = len8;
   assign tif.stop2 = mode_q[asc_pkg::MODE_STOP];
   assign tif.msb   = msb_first;
   assign tif.data  = txb_q;
   assign tif.full  = full_q;
   assign serial_out_pin = tif.pin;

   asc_tx #(
      .BIT_TICKS (BIT_TICKS)
   ) u_tx (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .unit_off (unit_off),
      .tif      (tif)
   );

   // Mode register survives power-off; it holds the power bit itself
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q <= asc_pkg::MODE_RST;
      end else if (ce && wr_mode) begin
         mode_q <= bus_wdata;
      end
   end

   // R5 transmit buffer write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txb_q <= asc_pkg::BUF_RST;
      end else if (ce && wr_tx) begin
         txb_q <= bus_wdata;
      end
   end

   // R18 full flag; a write in the take cycle still counts
   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         full_q <= 1'b0;
      end else if (sys_rst) begin
         full_q <= 1'b0;
      end else if (ce) begin
         if (!tx_en) begin
            full_q <= 1'b0;
         end else if (wr_tx) begin
            full_q <= 1'b1;
         end else if (tif.take) begin
            full_q <= 1'b0;
         end
      end
   end

   assign r_end  = tick && (rcnt_q == CW'(BIT_TICKS - 1));
   // R25 only first stop bit sampled
   assign rx_fin = r_end && (rst_q == asc_pkg::FR_STOP);
   // R3 overrun drops the character
   assign rx_load = rx_fin && !unread_q;

   // R1 seven-bit LSB first
   // R2 seven-bit MSB first
   assign rx_res = len8 ? rsh_q :
                   (msb_first ? {rsh_q[6:0], 1'b0} : {1'b0, rsh_q[7:1]});
   assign rx_x   = (^rx_res) ^ rpar_q;
   // R13 zero parity never checked
   assign pe_now = ((par == asc_pkg::PAR_ODD) && !rx_x) ||
                   ((par == asc_pkg::PAR_EVEN) && rx_x);

   // R23 errors at character end
   // R24 overrun from unread buffer
   always_comb begin
      err_new = 3'h0;
      if (rx_fin) begin
         err_new[asc_pkg::ERR_PAR] = pe_now;
         err_new[asc_pkg::ERR_FRM] = !rx_level;
         err_new[asc_pkg::ERR_OVR] = unread_q;
      end
   end

   // Receive frame sequencer; samples each bit at its middle
   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         rst_q  <= asc_pkg::FR_IDLE;
         rcnt_q <= '0;
         rsh_q  <= asc_pkg::BUF_RST;
         rn_q   <= 3'h0;
         rpar_q <= 1'b0;
      end else if (sys_rst || (ce && !rx_en)) begin
         // R10 synchronous receive reset
         rst_q  <= asc_pkg::FR_IDLE;
         rcnt_q <= '0;
         rsh_q  <= asc_pkg::BUF_RST;
         rn_q   <= 3'h0;
         rpar_q <= 1'b0;
      end else if (ce && tick) begin
         rcnt_q <= r_end ? '0 : rcnt_q + 1'b1;
         unique case (rst_q)
            // R20 low line starts reception
            asc_pkg::FR_IDLE: begin
               rcnt_q <= '0;
               if (!rx_level) begin
                  rst_q <= asc_pkg::FR_START;
               end
            end
            // A start that is gone by mid-bit is taken as noise
            asc_pkg::FR_START: begin
               if (rcnt_q == CW'(HALF - 1)) begin
                  rcnt_q <= '0;
                  rn_q   <= 3'h0;
                  rst_q  <= rx_level ? asc_pkg::FR_IDLE
                                     : asc_pkg::FR_DATA;
               end
            end
            // R14 seven or eight data bits
            asc_pkg::FR_DATA: if (r_end) begin
               rsh_q <= msb_first ? {rsh_q[6:0], rx_level}
                                  : {rx_level, rsh_q[7:1]};
               if (rn_q == (len8 ? 3'h7 : 3'h6)) begin
                  rst_q <= (par == asc_pkg::PAR_NONE) ? asc_pkg::FR_STOP
                                                      : asc_pkg::FR_PAR;
               end else begin
                  rn_q <= rn_q + 3'h1;
               end
            end
            asc_pkg::FR_PAR: if (r_end) begin
               rpar_q <= rx_level;
               rst_q  <= asc_pkg::FR_STOP;
            end
            // R15 receiver always one stop bit
            asc_pkg::FR_STOP: if (r_end) begin
               rst_q <= asc_pkg::FR_IDLE;
            end
            default: rst_q <= asc_pkg::FR_IDLE;
         endcase
      end
   end

   // R4 receive buffer load
   // R8 cleared to FF by power-off
   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         rxb_q <= asc_pkg::BUF_RST;
      end else if (sys_rst) begin
         rxb_q <= asc_pkg::BUF_RST;
      end else if (ce && rx_load) begin
         rxb_q <= rx_res;
      end
   end

   // Unread marker; a new load wins over a buffer read
   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         unread_q <= 1'b0;
      end else if (sys_rst || (ce && !rx_en)) begin
         unread_q <= 1'b0;
      end else if (ce) begin
         if (rx_load) begin
            unread_q <= 1'b1;
         end else if (rd_rx) begin
            unread_q <= 1'b0;
         end
      end
   end

   // R22 read clears, new error wins
   // R26 flags set with load and pulse
   always_ff @(posedge clk or posedge unit_off) begin
      if (unit_off) begin
         err_q <= asc_pkg::ERRST_RST[2:0];
      end else if (sys_rst || (ce && !rx_en)) begin
         err_q <= asc_pkg::ERRST_RST[2:0];
      end else if (ce) begin
         err_q <= (rd_err ? 3'h0 : err_q) | err_new;
      end
   end

   // R16 error routing
   always_ff @(posedge clk) begin
      if (sys_rst || unit_off) begin
         receive_done_irq  <= 1'b0;
         receive_error_irq <= 1'b0;
         transmit_done_irq <= 1'b0;
      end else if (ce) begin
         receive_error_irq <= rx_fin && (|err_new) && !route;
         receive_done_irq  <= rx_fin && (!(|err_new) || route);
         transmit_done_irq <= tif.done;
      end
   end

   // Read data; unmapped addresses and the reserved bits read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_rdata <= 8'h00;
      end else if (ce && bus_rd) begin
         case (bus_addr)
            asc_pkg::MODE_ADDR:  bus_rdata <= mode_q;
            asc_pkg::TXBUF_ADDR: bus_rdata <= txb_q;
            asc_pkg::RXBUF_ADDR: bus_rdata <= rxb_q;
            asc_pkg::ERRST_ADDR: bus_rdata <= {5'h00, err_q};
            asc_pkg::TXST_ADDR:  bus_rdata <= {6'h00, full_q, tif.busy};
            default:             bus_rdata <= 8'h00;
         endcase
      end
   end

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_RX7_LSB: assert property ( // R1
      ce && rx_load && !len8 && !msb_first |=> rxb_q[7] == 1'b0)
      else $error("seven-bit LSB-first character left bit 7 set");

   AST_RX7_MSB: assert property ( // R2
      ce && rx_load && !len8 && msb_first |=> rxb_q[0] == 1'b0)
      else $error("seven-bit MSB-first character left bit 0 set");

   AST_OVR_HOLD: assert property ( // R3
      ce && rx_fin && unread_q && rx_en
      |=> rxb_q == $past(rxb_q) && err_q[asc_pkg::ERR_OVR])
      else $error("overrun changed the receive buffer");

   AST_RXB_OFF: assert property ( // R8
      unit_off |-> rxb_q == asc_pkg::BUF_RST && err_q == 3'h0 && !full_q)
      else $error("unit state not reset while powered off");

   AST_TXB_FULL: assert property ( // R5
      ce && wr_tx && tx_en |=> full_q)
      else $error("transmit buffer write did not mark it full");

   if (BASE_DIV == 1) begin : g_ast_start
      AST_TX_START: assert property ( // R6
         ce && wr_tx && tx_en && !full_q && !tif.busy
         ##1 ce [*2] |-> ##[0:1] tif.take)
         else $error("first character not moved to the shifter");
   end

   AST_PIN_OFF: assert property ( // R11
      unit_off |-> serial_out_pin == 1'b1)
      else $error("output pin not high while powered off");

   AST_ZERO_PAR: assert property ( // R13
      $rose(err_q[asc_pkg::ERR_PAR]) |-> $past(par) != asc_pkg::PAR_ZERO)
      else $error("parity error flagged in zero-parity mode");

   AST_ROUTE: assert property ( // R16
      receive_error_irq |-> !receive_done_irq && !route)
      else $error("error interrupt raised with completion routing");

   AST_ERR_CLR: assert property ( // R22
      rd_err && rx_en && !rx_fin |=> err_q == 3'h0)
      else $error("error status read did not clear the flags");

   AST_FLAG_IRQ: assert property ( // R26
      $rose(|err_q) |-> receive_error_irq || receive_done_irq)
      else $error("error flag set without a reception interrupt");

   COV_OVERRUN: cover property (rx_fin && unread_q && ce);
   COV_RX7_MSB: cover property (rx_load && !len8 && msb_first && ce);
   COV_TX_B2B:  cover property (tif.take && tif.done && ce);
   COV_ERR_IRQ: cover property (receive_error_irq);
endmodule

// ### bench/asc_node.sv
// Remote serial node: sends frames to the core and samples its output.
// Assumes a bit lasts BIT clk cycles and the line idles high.
module asc_node #(
   parameter int BIT = 8
) (
   input  wire logic clk,
   input  wire logic tx_pin,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line = 1'b1;
   // Frame bits go out from bit 0 upward
   // Changes land just after an edge so the pin never races the sampler
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         line = f[i];
         repeat (BIT) @(posedge clk);
         #1;
      end
      line = 1'b1;
   endtask
   // Samples mid bit, eight data bits after the start bit
   task automatic recv(output logic [7:0] d);
      @(negedge tx_pin);
      repeat (BIT / 2 + BIT) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         d[i] = tx_pin;
         repeat (BIT) @(posedge clk);
      end
   endtask
endmodule

// ### bench/async_serial_core_tb.sv
// Self-checking bench for the serial core: registers, receive, transmit.
// Assumes a 50 MHz clock and a short bit time set through BIT_TICKS.
module async_serial_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BT = 8;
   logic        clk = 0, sys_rst = 1, ce = 1, bus_wr = 0, bus_rd = 0;
   logic        msb = 0, rdv = 0, tx_pin, rx_pin;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdat = 8'h00, rdat, d, r1;
   logic [6:0]  rv;
   logic [2:0]  irqs;
   logic [7:0]  exp_q[$];
   int          failures = 0, compares = 0, cyc = 0, seed = 29;
   always #10 clk = ~clk;
   asc_core #(.BIT_TICKS(BT), .BASE_DIV(1)) dut_u (.clk(clk),
      .sys_rst(sys_rst), .ce(ce), .bus_addr(addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(wdat), .bus_rdata(rdat),
      .msb_first(msb), .serial_in_pin(rx_pin), .serial_out_pin(tx_pin),
      .transmit_done_irq(irqs[0]), .receive_done_irq(irqs[1]),
      .receive_error_irq(irqs[2]));
   asc_node #(.BIT(BT)) node_u (.clk(clk), .tx_pin(tx_pin), .line(rx_pin));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   // One register access; a read leaves its expected value in the queue
   task automatic acc(input logic [15:0] a, input logic w,
                      input logic [7:0] v);
      @(posedge clk) #1;
      addr = a;
      wdat = v;
      bus_wr = w;
      bus_rd = !w;
      if (!w) exp_q.push_back(v);
      @(posedge clk) #1;
      bus_wr = 0;
      bus_rd = 0;
   endtask
   task automatic wirq(input int k);
      int n;
      for (n = 0; n < 400 && irqs[k] !== 1'b1; n++) @(posedge clk);
      check({7'h00, n < 400}, 8'h01);
   endtask
   task automatic close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Read data shows one cycle after the read strobe
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rdv <= bus_rd;
      if (rdv) check(rdat, exp_q.pop_front());
      if (cyc == 6000) begin
         failures++;
         close_out;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 0;
      acc(16'hFF50, 0, 8'h01);
      acc(16'hFF53, 0, 8'h00);
      acc(16'hFF52, 1, 8'h5A);
      acc(16'hFF52, 0, 8'hFF);
      acc(16'hFF51, 0, 8'hFF);
      acc(16'hFFFF, 0, 8'h00);
      // Power first, then 8-bit even parity reception
      // power before enable
      acc(16'hFF50, 1, 8'h80);
      acc(16'hFF50, 1, 8'hBC);
      r1 = 8'($random(seed));
      d = 8'($random(seed));
      fork
         node_u.send({1'b1, ^r1, r1, 1'b0}, 11);
         wirq(1);
      join
      fork
         node_u.send({1'b1, ^d, d, 1'b0}, 11);
         wirq(2);
      join
      acc(16'hFF53, 0, 8'h01);
      acc(16'hFF52, 0, r1);
      acc(16'hFF53, 0, 8'h00);
      // 7-bit MSB first, zero parity sent as one goes unchecked
      // receive off before format change
      acc(16'hFF50, 1, 8'h80);
      msb = 1;
      acc(16'hFF50, 1, 8'hA8);
      for (int i = 0; i < 7; i++) begin
         rv[i] = d[6 - i];
      end
      fork
         node_u.send({2'h3, rv, 1'b0}, 10);
         wirq(1);
      join
      acc(16'hFF52, 0, {d[6:0], 1'b0});
      acc(16'hFF53, 0, 8'h00);
      // 7-bit LSB first, wrong odd parity, completion routing
      acc(16'hFF50, 1, 8'h80);
      msb = 0;
      acc(16'hFF50, 1, 8'hB1);
      fork
         node_u.send({1'b1, ^d[6:0], d[6:0], 1'b0}, 10);
         wirq(1);
      join
      acc(16'hFF53, 0, 8'h04);
      acc(16'hFF52, 0, {1'b0, d[6:0]});
      // 8-bit one stop transmission, LSB first; receiver armed before write
      acc(16'hFF50, 1, 8'h80);
      acc(16'hFF50, 1, 8'hC4);
      fork
         // first write after enable, buffer empty
         acc(16'hFF51, 1, r1);
         node_u.recv(d);
         wirq(0);
      join
      check(d, r1);
      acc(16'hFF50, 1, 8'h80);
      acc(16'hFF50, 1, 8'h00);
      acc(16'hFF52, 0, 8'hFF);
      check({7'h00, tx_pin}, 8'h01);
      repeat (3) @(posedge clk);
      close_out;
   end
endmodule
